/* include/bmmcs_pkg.sv */
// Purpose: Shared constants for the bridge measurement control and status block
// Assumes: 8-bit control and status bytes, 16-bit measured-value registers
// Notes: Bit positions follow the process-image byte layout
package bmmcs_pkg;
	// ------------------------------------------------------------
	// Control byte fields
	// ------------------------------------------------------------
	localparam int CB_START = 0;
	localparam int CB_INHIBIT_CHAN = 1;
	localparam int CB_VIEW_SYMM = 2;
	localparam int CB_FREEZE = 3;
	localparam int CB_COUNTERS = 4;
	// ------------------------------------------------------------
	// Status byte fields
	// ------------------------------------------------------------
	localparam int SB_SIGN = 0;
	localparam int SB_ACK_CHAN = 1;
	localparam int SB_INVALID = 2;
	localparam int SB_FREEZE_ACK = 3;
	localparam int SB_FORCED = 4;
	localparam int SB_ERROR = 6;
	// ------------------------------------------------------------
	// Status word tolerance flags and calibration quality limits
	// ------------------------------------------------------------
	localparam int SW_TOL_A = 8;
	localparam int SW_TOL_B = 15;
	localparam logic [15:0] CNT_LIMIT_A = 16'h4000;
	localparam logic [15:0] CNT_LIMIT_B = 16'h4000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// ------------------------------------------------------------
	// Check / calibration sequencing
	// ------------------------------------------------------------
	localparam int CHECK_TIME_US = 10;
	localparam int CLK_MHZ = 100;
	localparam logic [15:0] CHECK_CYCLES = 16'(CHECK_TIME_US * CLK_MHZ);
	localparam logic [15:0] CALI_CYCLES = 16'(CHECK_TIME_US * CLK_MHZ);

	typedef enum logic [1:0] {
		BMMCS_IDLE = 2'b00,
		BMMCS_CALI = 2'b01,
		BMMCS_CHECK = 2'b10
	} bmmcs_seq_t;
endpackage

/* src/bmmcs_seq.sv */
// Purpose: Sequencer for a started check or calibration-then-check
// Assumes: start is a one-cycle pulse; manual selects calibration first
// Notes: A start while busy is ignored
`timescale 1ns/1ns
`default_nettype none
module bmmcs_seq
	import bmmcs_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic manual,
	output logic busy,
	output logic cali_active
);
	bmmcs_seq_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			BMMCS_IDLE: begin
				if (start) begin
					state_d = manual ? BMMCS_CALI : BMMCS_CHECK;
					cnt_d = manual ? CALI_CYCLES : CHECK_CYCLES;
				end
			end
			BMMCS_CALI: begin
				if (cnt_q == 16'h0001) begin
					state_d = BMMCS_CHECK;
					cnt_d = CHECK_CYCLES;
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			BMMCS_CHECK: begin
				if (cnt_q == 16'h0001) begin
					state_d = BMMCS_IDLE;
					cnt_d = 16'h0000;
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			default: begin
				state_d = BMMCS_IDLE;
				cnt_d = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= BMMCS_IDLE;
			cnt_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign busy = (state_q != BMMCS_IDLE);
	assign cali_active = (state_q == BMMCS_CALI);
endmodule
`default_nettype wire

/* src/bmmcs_mux.sv */
// Purpose: Selects the source shown in measured-value registers 1, 2, 3 and 5
// Assumes: All sources are 16-bit and valid each cycle
// Notes: Purely combinational
`timescale 1ns/1ns
`default_nettype none
module bmmcs_mux
	import bmmcs_pkg::*;
(
	input wire logic show_counters,
	input wire logic cal_view,
	input wire logic [15:0] weight,
	input wire logic [15:0] bridge_sig,
	input wire logic [15:0] ref_sig,
	input wire logic [15:0] test_val,
	input wire logic [15:0] sig_offset,
	input wire logic [15:0] ref_offset,
	input wire logic [15:0] diff_factor,
	input wire logic [15:0] cal_cnt0,
	input wire logic [15:0] cal_cnt1,
	input wire logic [15:0] cal_cnt2,
	output logic [15:0] sel1,
	output logic [15:0] sel2,
	output logic [15:0] sel3,
	output logic [15:0] sel5
);
	always_comb begin
		if (show_counters) begin // see RQ2
			sel1 = cal_view ? REG_RESET : weight;
			sel2 = cal_cnt0;
			sel3 = cal_cnt1;
			sel5 = cal_cnt2;
		end else if (cal_view) begin // see RQ6
			sel1 = REG_RESET;
			sel2 = sig_offset;
			sel3 = ref_offset;
			sel5 = diff_factor;
		end else begin // see RQ5
			sel1 = weight;
			sel2 = bridge_sig;
			sel3 = ref_sig;
			sel5 = test_val;
		end
	end
endmodule
`default_nettype wire

/* src/bmmcs_top.sv */
// Purpose: Process-data control and status handshake of a bridge measuring channel
// Assumes: Control byte arrives with its write strobe; manual mode comes from the
//   command register logic outside this block
//   Inputs are synchronous to clk
// Notes: Measurement sources are inputs; this block only maps, freezes and reports
//   Start acts only on a 0-to-1 change of the start bit between writes
// Behaviour
// RQ1: Flag counter tolerance excess in status word
// RQ2: Unfrozen: update registers; counters view optional
// RQ3: Frozen: hold registers one, two, three, five
// RQ4: Frozen: ignore show-counters bit
// RQ5: Normal, view clear: raw data shown
// RQ6: Normal, view set: calibration data shown
// RQ7: Manual: bit two inhibits symmetric measurement
// RQ8: Clearing inhibit request clears forced flag
// RQ9: Inhibit set suspends auto calibration, reference
// RQ10: Start bit begins check or calibration
// RQ11: Controller enables manual mode first
// RQ12: Status byte sent in input image
// RQ13: Status byte bit layout
// RQ14: Freeze acknowledge confirms write protection
// RQ15: Value-invalid flags invalid process data
// RQ16: Sign bit: one means negative
// RQ17: Manual: echo selected channel in bit one
`timescale 1ns/1ns
`default_nettype none
module bmmcs_top
	import bmmcs_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] process_control_byte,
	input wire logic control_write,
	input wire logic manual_mode,
	input wire logic symmetry_feature_enable,
	input wire logic internal_error,
	input wire logic forced_calibration_event,
	input wire logic sample_valid,
	input wire logic [15:0] weight,
	input wire logic [15:0] bridge_sig,
	input wire logic [15:0] ref_sig,
	input wire logic [15:0] test_val,
	input wire logic [15:0] sig_offset,
	input wire logic [15:0] ref_offset,
	input wire logic [15:0] diff_factor,
	input wire logic [15:0] cal_cnt0,
	input wire logic [15:0] cal_cnt1,
	input wire logic [15:0] cal_cnt2,
	output logic [7:0] process_status_byte,
	output logic [15:0] status_word,
	output logic [15:0] meas_reg1,
	output logic [15:0] meas_reg2,
	output logic [15:0] meas_reg3,
	output logic [15:0] meas_reg5,
	output logic symmetric_enable,
	output logic auto_cali_enable,
	output logic ref_cycle_enable,
	output logic measure_ref_channel,
	output logic check_busy,
	output logic cali_busy
);
	// ------------------------------------------------------------
	// Control byte capture
	// ------------------------------------------------------------
	logic [7:0] ctrl_q, ctrl_d;
	logic start_q, start_d;

	always_comb begin
		ctrl_d = ctrl_q;
		start_d = 1'b0;
		if (control_write) begin
			ctrl_d = process_control_byte;
			// Level-held start bit only fires once per rising edge
			start_d = process_control_byte[CB_START] & ~ctrl_q[CB_START]; // see RQ10
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= BYTE_RESET;
			start_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			start_q <= start_d;
		end
	end

	logic freeze;
	logic show_counters;
	logic cal_view;
	// Freeze masks the counters view here, before the mux ever sees it
	assign freeze = ctrl_q[CB_FREEZE];
	assign show_counters = ctrl_q[CB_COUNTERS] & ~freeze; // see RQ4
	// Manual mode reuses bit two as symmetry inhibit, so no calibration view then
	assign cal_view = ctrl_q[CB_VIEW_SYMM] & ~manual_mode;

	// ------------------------------------------------------------
	// Sequencer and source selection
	// ------------------------------------------------------------
	logic seq_busy;
	logic seq_cali;

	// A start that arrives while a check or calibration runs is dropped
	bmmcs_seq u_seq (
		.clk(clk),
		.reset(reset),
		.start(start_q), // see RQ10
		.manual(manual_mode),
		.busy(seq_busy),
		.cali_active(seq_cali)
	);

	logic [15:0] sel1, sel2, sel3, sel5;

	bmmcs_mux u_mux (
		.show_counters(show_counters),
		.cal_view(cal_view),
		.weight(weight),
		.bridge_sig(bridge_sig),
		.ref_sig(ref_sig),
		.test_val(test_val),
		.sig_offset(sig_offset),
		.ref_offset(ref_offset),
		.diff_factor(diff_factor),
		.cal_cnt0(cal_cnt0),
		.cal_cnt1(cal_cnt1),
		.cal_cnt2(cal_cnt2),
		.sel1(sel1),
		.sel2(sel2),
		.sel3(sel3),
		.sel5(sel5)
	);

	// ------------------------------------------------------------
	// Measured-value registers
	// ------------------------------------------------------------
	// The mux keeps running while frozen, so a release shows the current view at once
	logic [15:0] r1_q, r1_d, r2_q, r2_d, r3_q, r3_d, r5_q, r5_d;

	always_comb begin
		r1_d = r1_q;
		r2_d = r2_q;
		r3_d = r3_q;
		r5_d = r5_q;
		if (!freeze) begin // see RQ2
			r1_d = sel1;
			r2_d = sel2;
			r3_d = sel3;
			r5_d = sel5;
		end // see RQ3
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r1_q <= REG_RESET;
			r2_q <= REG_RESET;
			r3_q <= REG_RESET;
			r5_q <= REG_RESET;
		end else begin
			r1_q <= r1_d;
			r2_q <= r2_d;
			r3_q <= r3_d;
			r5_q <= r5_d;
		end
	end

	// ------------------------------------------------------------
	// Shared decode functions
	// ------------------------------------------------------------
	// Bit two means symmetry inhibit only in manual operation
	function automatic logic symmetric_enable_calc(input logic man, input logic inh,
		input logic feat);
		symmetric_enable_calc = man ? (feat & ~inh) : feat;
	endfunction

	// Only strictly above the limit counts as out of tolerance
	function automatic logic over_limit(input logic [15:0] cnt, input logic [15:0] lim);
		over_limit = (cnt > lim);
	endfunction

	// ------------------------------------------------------------
	// Forced calibration flag
	// ------------------------------------------------------------
	logic forced_q, forced_d;
	logic inhibit;
	assign inhibit = ctrl_q[CB_INHIBIT_CHAN] & ~manual_mode;

	// Clearing is a level, so in normal mode with inhibit low an event shows for one cycle
	always_comb begin
		forced_d = forced_q;
		if (!manual_mode && !ctrl_q[CB_INHIBIT_CHAN]) begin
			forced_d = 1'b0; // see RQ8
		end
		// A new forced event beats a clear in the same cycle
		if (forced_calibration_event) begin
			forced_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			forced_q <= 1'b0;
		end else begin
			forced_q <= forced_d;
		end
	end

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	logic sym_q, sym_d, auto_q, auto_d, refc_q, refc_d, chan_q, chan_d;
	logic chk_q, chk_d, cal_q, cal_d;

	always_comb begin
		sym_d = symmetric_enable_calc(manual_mode, ctrl_q[CB_VIEW_SYMM],
			symmetry_feature_enable); // see RQ7
		auto_d = ~inhibit; // see RQ9
		refc_d = ~inhibit; // see RQ9
		chan_d = manual_mode & ctrl_q[CB_INHIBIT_CHAN]; // see RQ17
		chk_d = seq_busy & ~seq_cali;
		cal_d = seq_cali;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sym_q <= 1'b0;
			auto_q <= 1'b1;
			refc_q <= 1'b1;
			chan_q <= 1'b0;
			chk_q <= 1'b0;
			cal_q <= 1'b0;
		end else begin
			sym_q <= sym_d;
			auto_q <= auto_d;
			refc_q <= refc_d;
			chan_q <= chan_d;
			chk_q <= chk_d;
			cal_q <= cal_d;
		end
	end

	// ------------------------------------------------------------
	// Status byte
	// ------------------------------------------------------------
	logic [7:0] sb_q, sb_d;

	always_comb begin
		sb_d = BYTE_RESET; // see RQ13
		sb_d[SB_ERROR] = internal_error;
		sb_d[SB_FORCED] = forced_d;
		sb_d[SB_FREEZE_ACK] = freeze; // see RQ14
		// A check or calibration in progress means no live process value
		sb_d[SB_INVALID] = ~sample_valid | seq_busy; // see RQ15
		sb_d[SB_ACK_CHAN] = manual_mode ? ctrl_q[CB_INHIBIT_CHAN] : inhibit; // see RQ17
		// Taken from the next register value so sign and data change together
		sb_d[SB_SIGN] = r1_d[15]; // see RQ16
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sb_q <= BYTE_RESET;
		end else begin
			sb_q <= sb_d; // see RQ12
		end
	end

	// ------------------------------------------------------------
	// Status word
	// ------------------------------------------------------------
	logic [15:0] sw_q, sw_d;

	// Counters are compared live, so the flags still move while registers are frozen
	always_comb begin
		sw_d = REG_RESET;
		sw_d[SW_TOL_A] = over_limit(cal_cnt0, CNT_LIMIT_A)
			| over_limit(cal_cnt1, CNT_LIMIT_A); // see RQ1
		sw_d[SW_TOL_B] = over_limit(cal_cnt2, CNT_LIMIT_B); // see RQ1
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sw_q <= REG_RESET;
		end else begin
			sw_q <= sw_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign process_status_byte = sb_q;
	assign status_word = sw_q;
	assign meas_reg1 = r1_q;
	assign meas_reg2 = r2_q;
	assign meas_reg3 = r3_q;
	assign meas_reg5 = r5_q;
	assign symmetric_enable = sym_q;
	assign auto_cali_enable = auto_q;
	assign ref_cycle_enable = refc_q;
	assign measure_ref_channel = chan_q;
	assign check_busy = chk_q;
	assign cali_busy = cal_q;
endmodule
`default_nettype wire

/* dv/bmmcs_fieldbus_model.sv */
// Purpose: Fieldbus controller model writing the process control byte
// Assumes: One strobe cycle per byte, written at the falling edge
// Notes: The byte lines show the inverse value once the strobe is gone
`timescale 1ns/1ns
`default_nettype none
module bmmcs_fieldbus_model (
	input wire logic clk,
	output logic [7:0] process_control_byte,
	output logic control_write,
	output logic manual_mode
);
	initial begin
		process_control_byte = 8'h00;
		control_write = 1'b0;
		manual_mode = 1'b0;
	end
	task automatic send(logic [7:0] b);
		@(negedge clk);
		process_control_byte = b;
		control_write = 1'b1;
		@(negedge clk);
		control_write = 1'b0;
		process_control_byte = ~b;
	endtask
	// Mode changes only between bytes, ahead of any manual meaning
	task automatic set_manual(logic m);
		@(negedge clk);
		manual_mode = m;
	endtask
endmodule
`default_nettype wire

/* dv/bmmcs_assertions.sv */
// Purpose: Port-level checks of the control and status handshake
// Assumes: One clock domain, reset asynchronous active high
// Notes: Write antecedents need quiet strobe cycles after the write
`timescale 1ns/1ns
`default_nettype none
module bmmcs_checker
	import bmmcs_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] process_control_byte,
	input wire logic control_write,
	input wire logic manual_mode,
	input wire logic symmetry_feature_enable,
	input wire logic internal_error,
	input wire logic forced_calibration_event,
	input wire logic [15:0] cal_cnt0,
	input wire logic [15:0] cal_cnt1,
	input wire logic [15:0] cal_cnt2,
	input wire logic [7:0] process_status_byte,
	input wire logic [15:0] status_word,
	input wire logic [15:0] meas_reg1,
	input wire logic [15:0] meas_reg2,
	input wire logic [15:0] meas_reg3,
	input wire logic [15:0] meas_reg5,
	input wire logic symmetric_enable,
	input wire logic auto_cali_enable,
	input wire logic ref_cycle_enable,
	input wire logic measure_ref_channel,
	input wire logic check_busy,
	input wire logic cali_busy
);
	default clocking dclk @(posedge clk); endclocking
	default disable iff (reset);
	wire logic ack = process_status_byte[SB_FREEZE_ACK];
	property p_tol;
		!$past(reset) |-> status_word == {$past(cal_cnt2) > CNT_LIMIT_B, 6'h00,
			$past(cal_cnt0) > CNT_LIMIT_A || $past(cal_cnt1) > CNT_LIMIT_A, 8'h00};
	endproperty
	property p_err;
		$stable(internal_error) [*2] |-> process_status_byte[SB_ERROR] == internal_error;
	endproperty
	property p_sign;
		$stable(meas_reg1) [*2] |-> process_status_byte[SB_SIGN] == meas_reg1[15];
	endproperty
	property p_hold;
		ack && $past(ack) |-> $stable({meas_reg1, meas_reg2, meas_reg3, meas_reg5});
	endproperty
	property p_ack;
		control_write ##1 !control_write [*3] |-> ack == $past(process_control_byte[3], 3);
	endproperty
	property p_inhib;
		control_write && !manual_mode ##1 (!control_write && !manual_mode) [*2]
			|-> auto_cali_enable == !$past(process_control_byte[1], 2)
			&& ref_cycle_enable == !$past(process_control_byte[1], 2);
	endproperty
	property p_man;
		control_write && manual_mode ##1 (!control_write && manual_mode) [*2]
			|-> measure_ref_channel == $past(process_control_byte[1], 2) && symmetric_enable
			== ($past(symmetry_feature_enable) && !$past(process_control_byte[2], 2));
	endproperty
	property p_inval;
		check_busy || cali_busy |-> process_status_byte[SB_INVALID];
	endproperty
	property p_forced;
		forced_calibration_event |-> ##[1:2] process_status_byte[SB_FORCED];
	endproperty
	property p_seq;
		$fell(cali_busy) |-> ##[0:2] check_busy;
	endproperty
	a_tol: assert property (p_tol) else $error("tolerance flags wrong");
	a_err: assert property (p_err) else $error("error bit wrong");
	a_sign: assert property (p_sign) else $error("sign bit wrong");
	a_hold: assert property (p_hold) else $error("frozen register moved");
	a_ack: assert property (p_ack) else $error("freeze ack wrong");
	a_inhib: assert property (p_inhib) else $error("inhibit wrong");
	a_man: assert property (p_man) else $error("manual bits wrong");
	a_inval: assert property (p_inval) else $error("invalid not set");
	a_forced: assert property (p_forced) else $error("forced not set");
	a_seq: assert property (p_seq) else $error("no check after cal");
	c_frz: cover property (ack);
	c_cal: cover property ($rose(cali_busy));
	c_frc: cover property (process_status_byte[SB_FORCED]);
endmodule
bind bmmcs_top bmmcs_checker u_bmmcs_checker(.clk, .reset, .process_control_byte,
	.control_write, .manual_mode, .symmetry_feature_enable, .internal_error,
	.forced_calibration_event, .cal_cnt0, .cal_cnt1, .cal_cnt2, .process_status_byte,
	.status_word, .meas_reg1, .meas_reg2, .meas_reg3, .meas_reg5, .symmetric_enable,
	.auto_cali_enable, .ref_cycle_enable, .measure_ref_channel, .check_busy, .cali_busy);
`default_nettype wire

/* dv/bridge_meas_mode_control_status_tb.sv */
// Purpose: Self-checking bench of the control and status handshake
// Assumes: Outputs settle within three cycles of a control write
// Notes: Driver queues expectations, a monitor compares them
`timescale 1ns/1ns
`default_nettype none
module bridge_meas_mode_control_status_tb;
	import bmmcs_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic symmetry_feature_enable = 1'b0;
	logic internal_error = 1'b0;
	logic forced_calibration_event = 1'b0;
	logic sample_valid = 1'b1;
	logic control_write, manual_mode;
	logic [7:0] process_control_byte, process_status_byte;
	logic [15:0] weight, bridge_sig, ref_sig, test_val, sig_offset, ref_offset, diff_factor;
	logic [15:0] cal_cnt0, cal_cnt1, cal_cnt2, status_word;
	logic [15:0] meas_reg1, meas_reg2, meas_reg3, meas_reg5;
	logic symmetric_enable, auto_cali_enable, ref_cycle_enable;
	logic measure_ref_channel, check_busy, cali_busy;
	typedef struct {int id; logic [15:0] v;} bmmcs_note_t;
	bmmcs_note_t q[$];
	bmmcs_note_t n;
	int miscompares = 0;
	int n_compared = 0;
	event look;
	string nm[8] = '{"reg1", "reg2", "reg3", "reg5", "status", "word", "flags", "busy"};
	always #5 clk = ~clk;
	bmmcs_fieldbus_model u_fb(.clk, .process_control_byte, .control_write, .manual_mode);
	bmmcs_top u_bmmcs_top(.clk, .reset, .process_control_byte, .control_write, .manual_mode,
		.symmetry_feature_enable, .internal_error, .forced_calibration_event, .sample_valid,
		.weight, .bridge_sig, .ref_sig, .test_val, .sig_offset, .ref_offset, .diff_factor,
		.cal_cnt0, .cal_cnt1, .cal_cnt2, .process_status_byte, .status_word, .meas_reg1,
		.meas_reg2, .meas_reg3, .meas_reg5, .symmetric_enable, .auto_cali_enable,
		.ref_cycle_enable, .measure_ref_channel, .check_busy, .cali_busy);
	function automatic logic [15:0] obs(int id);
		case (id)
			0: return meas_reg1;
			1: return meas_reg2;
			2: return meas_reg3;
			3: return meas_reg5;
			4: return {8'h00, process_status_byte};
			5: return status_word;
			6: return {12'h000, symmetric_enable, auto_cali_enable, ref_cycle_enable,
				measure_ref_channel};
			default: return {14'h0000, cali_busy, check_busy};
		endcase
	endfunction
	function automatic logic [15:0] stb(logic f, logic z, logic i, logic a, logic g);
		return {9'h000, internal_error, 1'b0, f, z, i, a, g};
	endfunction
	always @(look) begin
		while (q.size() > 0) begin
			n = q.pop_front();
			n_compared++;
			if (obs(n.id) !== n.v) begin
				miscompares++;
				$display("[FAIL] %s expected %h seen %h", nm[n.id], n.v, obs(n.id));
			end
		end
	end
	task automatic ex(int id, logic [15:0] v);
		q.push_back('{id, v});
	endtask
	task automatic wrap_up();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask
	task automatic rnd();
		@(negedge clk);
		{weight, bridge_sig, ref_sig, test_val} = {$urandom, $urandom};
		{sig_offset, ref_offset, diff_factor} = 48'({$urandom, $urandom});
		{cal_cnt0, cal_cnt1, cal_cnt2} = 48'({$urandom, $urandom});
		symmetry_feature_enable = 1'($urandom);
	endtask
	task automatic wt(logic [15:0] v, int lim);
		int k;
		k = 0;
		while (obs(7) !== v && k < lim) begin
			@(negedge clk);
			k++;
		end
		if (k >= lim) begin
			miscompares++;
			$display("[FAIL] busy expected %h seen %h", v, obs(7));
			wrap_up();
		end
	endtask
	task automatic rst();
		reset = 1'b1;
		repeat (9) @(negedge clk);
		for (int k = 0; k < 6; k++)
			ex(k, 16'h0000);
		ex(6, 16'h0006);
		-> look;
		@(negedge clk);
		reset = 1'b0;
	endtask
	task automatic maps(logic [7:0] c);
		logic [15:0] e1;
		rnd();
		u_fb.send(c);
		settle();
		e1 = c[2] ? 16'h0000 : weight;
		ex(0, e1);
		ex(1, c[4] ? cal_cnt0 : c[2] ? sig_offset : bridge_sig);
		ex(2, c[4] ? cal_cnt1 : c[2] ? ref_offset : ref_sig);
		ex(3, c[4] ? cal_cnt2 : c[2] ? diff_factor : test_val);
		ex(4, stb(1'b0, 1'b0, 1'b0, 1'b0, e1[15]));
		ex(6, {12'h000, symmetry_feature_enable, 2'b11, 1'b0});
		-> look;
	endtask
	task automatic go(logic m);
		u_fb.set_manual(m);
		u_fb.send(8'h00);
		u_fb.send(8'h01);
		if (m)
			wt(16'h0002, 10);
		wt(16'h0001, m ? CALI_CYCLES + 16 : 10);
		ex(4, stb(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
		-> look;
		wt(16'h0000, CHECK_CYCLES + 16);
		settle();
		ex(4, stb(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
		-> look;
	endtask
	initial begin
		logic [63:0] hv;
		{weight, bridge_sig, ref_sig, test_val, sig_offset} = 80'h0;
		{ref_offset, diff_factor, cal_cnt0, cal_cnt1, cal_cnt2} = 80'h0;
		void'($urandom(74));
		rst();
		for (int k = 0; k < 4; k++) begin
			internal_error = k[0];
			maps({3'h0, k[1], 1'b0, k[0], 2'h0});
		end
		maps(8'h00);
		hv = {weight, bridge_sig, ref_sig, test_val};
		u_fb.send(8'h08);
		settle();
		rnd();
		u_fb.send(8'h18);
		settle();
		for (int k = 0; k < 4; k++)
			ex(k, hv[63 - 16 * k -: 16]);
		ex(4, stb(1'b0, 1'b1, 1'b0, 1'b0, hv[63]));
		-> look;
		maps(8'h00);
		for (int k = 0; k < 4; k++) begin
			@(negedge clk);
			{cal_cnt0, cal_cnt1, cal_cnt2} = {CNT_LIMIT_A, CNT_LIMIT_A, CNT_LIMIT_B};
			if (k == 1)
				cal_cnt0 = CNT_LIMIT_A + 16'h0001;
			if (k == 2)
				cal_cnt1 = CNT_LIMIT_A + 16'h0001;
			if (k == 3)
				cal_cnt2 = CNT_LIMIT_B + 16'h0001;
			settle();
			ex(5, k == 3 ? 16'h8000 : k > 0 ? 16'h0100 : 16'h0000);
			-> look;
		end
		weight = 16'h1234;
		internal_error = 1'($urandom);
		u_fb.send(8'h02);
		forced_calibration_event = 1'b1;
		@(negedge clk);
		forced_calibration_event = 1'b0;
		settle();
		ex(6, {12'h000, symmetry_feature_enable, 3'b000});
		ex(4, stb(1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
		-> look;
		u_fb.send(8'h00);
		settle();
		ex(4, stb(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
		-> look;
		u_fb.set_manual(1'b1);
		symmetry_feature_enable = 1'b1;
		for (int k = 0; k < 4; k++) begin
			u_fb.send({5'h00, k[1:0], 1'b0});
			settle();
			ex(6, {12'h000, ~k[1], 2'b11, k[0]});
			ex(4, stb(1'b0, 1'b0, 1'b0, k[0], 1'b0));
			-> look;
		end
		go(1'b1);
		go(1'b0);
		sample_valid = 1'b0;
		settle();
		ex(4, stb(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
		-> look;
		@(negedge clk);
		sample_valid = 1'b1;
		rst();
		@(negedge clk);
		wrap_up();
	end
endmodule
`default_nettype wire
